// ### tbc_pkg.sv
package tbc_pkg;
  // Byte addresses of the register map, one aligned word each
  localparam logic [7:0] ADDR_CNT_LO  = 8'h00;
  localparam logic [7:0] ADDR_CNT_HI  = 8'h04;
  localparam logic [7:0] ADDR_CMPA_LO = 8'h08;
  localparam logic [7:0] ADDR_CMPA_HI = 8'h0C;
  localparam logic [7:0] ADDR_CMPB_LO = 8'h10;
  localparam logic [7:0] ADDR_CMPB_HI = 8'h14;
  localparam logic [7:0] ADDR_CAP_LO  = 8'h18;
  localparam logic [7:0] ADDR_CAP_HI  = 8'h1C;
  localparam logic [7:0] ADDR_CTRL_A  = 8'h20;
  localparam logic [7:0] ADDR_CTRL_B  = 8'h24;
  localparam logic [7:0] ADDR_FLAG    = 8'h28;
  localparam logic [7:0] ADDR_MASK    = 8'h2C;
  localparam logic [7:0] ADDR_CAPSRC  = 8'h30;

  // Control B fields
  localparam int CLKSEL_LSB = 0;
  localparam int MODE_HI_LSB = 3;
  localparam int CAP_EDGE_BIT = 6;
  localparam int NOISE_EN_BIT = 7;
  // Control A fields
  localparam int MODE_LO_LSB = 0;
  // Flag and mask bit positions
  localparam int FLG_OVF  = 0;
  localparam int FLG_CMPB = 1;
  localparam int FLG_CMPA = 2;
  localparam int FLG_CAP  = 3;

  // Clock select codes
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;

  // Count range values
  localparam logic [15:0] CNT_FLOOR = 16'h0000;
  localparam logic [15:0] CNT_MAX   = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT  = 16'h00FF;
  localparam logic [15:0] TOP_9BIT  = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;

  // Operating mode codes (4 bits)
  localparam logic [3:0] MD_NORMAL   = 4'h0;
  localparam logic [3:0] MD_PC8      = 4'h1;
  localparam logic [3:0] MD_PC9      = 4'h2;
  localparam logic [3:0] MD_PC10     = 4'h3;
  localparam logic [3:0] MD_CTC_A    = 4'h4;
  localparam logic [3:0] MD_FP8      = 4'h5;
  localparam logic [3:0] MD_FP9      = 4'h6;
  localparam logic [3:0] MD_FP10     = 4'h7;
  localparam logic [3:0] MD_PFC_CAP  = 4'h8;
  localparam logic [3:0] MD_PFC_A    = 4'h9;
  localparam logic [3:0] MD_PC_CAP   = 4'hA;
  localparam logic [3:0] MD_PC_A     = 4'hB;
  localparam logic [3:0] MD_CTC_CAP  = 4'hC;
  localparam logic [3:0] MD_FP_CAP   = 4'hE;
  localparam logic [3:0] MD_FP_A     = 4'hF;

  // Prescaler width and noise filter length
  localparam int PRESC_W = 10;
  localparam logic [1:0] NOISE_LEN = 2'h3;

  // AHB-Lite transfer codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

// ### tbc_core.sv
// Notes on behaviour
// - One 8-bit holding register shared by all wide registers.
// - Counter, compares and capture are 16 bits, reached as two bytes.
// - Low-byte write loads held high byte and new low byte together.
// - Low-byte read copies that register's high byte into holding register.
// - Compare value reads bypass the holding register, leaving it unchanged.
// - Counter clocked by prescaler taps or external pin, edge selectable.
// - With no clock source selected the counter does not advance.
// - Buffered compare values compared continuously; results drive wave outputs.
// - Compare match sets the channel's match flag.
// - Selected capture edge copies counter into capture value.
// - Capture path has a digital noise filter.
// - Count floor recognised at 0x0000.
// - Absolute maximum recognised at 0xFFFF.
// - Ceiling is 0x00FF, 0x01FF, 0x03FF, compare A or capture by mode.
// - Compare A as PWM ceiling: no channel A PWM, stays double buffered.
// - Capture-defined ceiling leaves compare A free for PWM.
// - Interrupt requests in a shared flag register, each maskable.
// - Two control registers are plain 8-bit, any access order.
// - A CPU counter write beats any clear or count that cycle.
//
// Chosen here: the register offsets and the AHB-Lite slave port.
module tbc_core
  import tbc_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        external_count_pin,
  input  wire logic        capture_input_pin,
  input  wire logic        comparator_out,
  output logic             wave_out_a,
  output logic             wave_out_b,
  output logic [3:0]       irq_req
);
  import tbc_pkg::*;

  logic [7:0]  hold_ff;
  logic [15:0] timer_count_ff, compare_value_a_ff, compare_value_b_ff, capture_value_ff;
  logic [15:0] cmpa_buf_ff, cmpb_buf_ff;
  logic [7:0]  timer_control_a_ff, timer_control_b_ff;
  logic [3:0]  timer_flag_register_ff, timer_mask_register_ff;
  logic        cap_src_ff;
  logic        dir_down_ff;
  logic [PRESC_W-1:0] presc_ff;
  logic [1:0]  ext_sync_ff, cap_sync_ff, cmp_sync_ff;
  logic        ext_prev_ff, cap_filt_ff;
  logic [1:0]  noise_cnt_ff;
  logic        wr_pend_ff;
  logic [7:0]  wr_addr_ff;
  logic        wave_a_ff, wave_b_ff;
  logic [31:0] hrdata_ff;
  logic [3:0]  irq_ff;

  logic [3:0]  mode;
  logic [2:0]  clk_sel;
  logic        tick, ext_edge, cap_raw, cap_event;
  logic [15:0] top_val;
  logic        at_floor, at_max, at_top, dual_slope, top_from_a, top_from_cap, pwm_mode;
  logic        rd_req, wr_low_cnt, wr_low_cap, wr_low_a, wr_low_b;
  logic        match_a, match_b;
  logic [7:0]  wb;
  logic [7:0]  ra;

  assign mode    = {timer_control_b_ff[MODE_HI_LSB+1:MODE_HI_LSB], timer_control_a_ff[MODE_LO_LSB+1:MODE_LO_LSB]};
  assign clk_sel = timer_control_b_ff[CLKSEL_LSB+2:CLKSEL_LSB];
  assign wb      = hwdata[7:0];
  assign ra      = haddr[7:0];
  assign rd_req  = hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;

  // Write data arrives one cycle after the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
    end else if (hready) begin
      wr_pend_ff <= hsel && htrans == HTRANS_NONSEQ && hwrite;
      wr_addr_ff <= ra;
    end
  end

  assign wr_low_cnt = wr_pend_ff && wr_addr_ff == ADDR_CNT_LO;
  assign wr_low_cap = wr_pend_ff && wr_addr_ff == ADDR_CAP_LO;
  assign wr_low_a   = wr_pend_ff && wr_addr_ff == ADDR_CMPA_LO;
  assign wr_low_b   = wr_pend_ff && wr_addr_ff == ADDR_CMPB_LO;

  // Zero-wait slave, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Shared holding register: high-byte writes and low-byte reads
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hold_ff <= 8'h00;
    end else if (wr_pend_ff && (wr_addr_ff == ADDR_CNT_HI || wr_addr_ff == ADDR_CMPA_HI ||
                                wr_addr_ff == ADDR_CMPB_HI || wr_addr_ff == ADDR_CAP_HI)) begin
      hold_ff <= wb;
    end else if (rd_req && ra == ADDR_CNT_LO) begin
      hold_ff <= timer_count_ff[15:8];
    end else if (rd_req && ra == ADDR_CAP_LO) begin
      hold_ff <= capture_value_ff[15:8];
    end
  end

  // Read data; compare reads return bytes directly
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (rd_req) begin
      case (ra)
        ADDR_CNT_LO:  hrdata_ff <= {24'h000000, timer_count_ff[7:0]};
        ADDR_CNT_HI:  hrdata_ff <= {24'h000000, hold_ff};
        ADDR_CMPA_LO: hrdata_ff <= {24'h000000, cmpa_buf_ff[7:0]};
        ADDR_CMPA_HI: hrdata_ff <= {24'h000000, cmpa_buf_ff[15:8]};
        ADDR_CMPB_LO: hrdata_ff <= {24'h000000, cmpb_buf_ff[7:0]};
        ADDR_CMPB_HI: hrdata_ff <= {24'h000000, cmpb_buf_ff[15:8]};
        ADDR_CAP_LO:  hrdata_ff <= {24'h000000, capture_value_ff[7:0]};
        ADDR_CAP_HI:  hrdata_ff <= {24'h000000, hold_ff};
        ADDR_CTRL_A:  hrdata_ff <= {24'h000000, timer_control_a_ff};
        ADDR_CTRL_B:  hrdata_ff <= {24'h000000, timer_control_b_ff};
        ADDR_FLAG:    hrdata_ff <= {28'h0000000, timer_flag_register_ff};
        ADDR_MASK:    hrdata_ff <= {28'h0000000, timer_mask_register_ff};
        ADDR_CAPSRC:  hrdata_ff <= {31'h00000000, cap_src_ff};
        default:      hrdata_ff <= 32'h0000_0000;
      endcase
    end
  end
  assign hrdata = hrdata_ff;

  // Plain byte control registers, no holding register involved
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_control_a_ff <= 8'h00;
      timer_control_b_ff <= 8'h00;
      timer_mask_register_ff <= 4'h0;
      cap_src_ff <= 1'b0;
    end else if (wr_pend_ff) begin
      if (wr_addr_ff == ADDR_CTRL_A) timer_control_a_ff <= wb;
      if (wr_addr_ff == ADDR_CTRL_B) timer_control_b_ff <= wb;
      if (wr_addr_ff == ADDR_MASK) timer_mask_register_ff <= wb[3:0];
      if (wr_addr_ff == ADDR_CAPSRC) cap_src_ff <= wb[0];
    end
  end

  // Free-running prescaler
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) presc_ff <= '0;
    else presc_ff <= presc_ff + 1'b1;
  end

  // Pin synchronisers; first stage feeds only the second
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_sync_ff <= 2'b00;
      cap_sync_ff <= 2'b00;
      cmp_sync_ff <= 2'b00;
      ext_prev_ff <= 1'b0;
    end else begin
      ext_sync_ff <= {ext_sync_ff[0], external_count_pin};
      cap_sync_ff <= {cap_sync_ff[0], capture_input_pin};
      cmp_sync_ff <= {cmp_sync_ff[0], comparator_out};
      ext_prev_ff <= ext_sync_ff[1];
    end
  end
  assign ext_edge = ext_sync_ff[1] ^ ext_prev_ff;

  // Tick selection by source and edge
  always_comb begin
    case (clk_sel)
      CS_STOP:     tick = 1'b0;
      CS_DIV1:     tick = 1'b1;
      CS_DIV8:     tick = presc_ff[2:0] == 3'h7;
      CS_DIV64:    tick = presc_ff[5:0] == 6'h3F;
      CS_DIV256:   tick = presc_ff[7:0] == 8'hFF;
      CS_DIV1024:  tick = presc_ff == 10'h3FF;
      CS_EXT_FALL: tick = ext_edge && !ext_sync_ff[1];
      CS_EXT_RISE: tick = ext_edge && ext_sync_ff[1];
      default:     tick = 1'b0;
    endcase
  end

  // Ceiling by mode
  assign top_from_a   = mode == MD_CTC_A || mode == MD_PFC_A || mode == MD_PC_A || mode == MD_FP_A;
  assign top_from_cap = mode == MD_CTC_CAP || mode == MD_PFC_CAP || mode == MD_PC_CAP || mode == MD_FP_CAP;
  always_comb begin
    case (mode)
      MD_PC8, MD_FP8:   top_val = TOP_8BIT;
      MD_PC9, MD_FP9:   top_val = TOP_9BIT;
      MD_PC10, MD_FP10: top_val = TOP_10BIT;
      default:          top_val = top_from_a ? compare_value_a_ff :
                                  (top_from_cap ? capture_value_ff : CNT_MAX);
    endcase
  end
  assign dual_slope = mode inside {MD_PC8, MD_PC9, MD_PC10, MD_PFC_CAP, MD_PFC_A, MD_PC_CAP, MD_PC_A};
  assign pwm_mode   = mode != MD_NORMAL && mode != MD_CTC_A && mode != MD_CTC_CAP;
  assign at_floor   = timer_count_ff == CNT_FLOOR;
  assign at_max     = timer_count_ff == CNT_MAX;
  assign at_top     = timer_count_ff == top_val;

  // Counter; CPU write has priority
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_count_ff <= 16'h0000;
      dir_down_ff    <= 1'b0;
    end else if (wr_low_cnt) begin
      timer_count_ff <= {hold_ff, wb};
    end else if (tick) begin
      if (dual_slope) begin
        if (!dir_down_ff && at_top) begin
          dir_down_ff    <= 1'b1;
          timer_count_ff <= timer_count_ff - 16'h0001;
        end else if (dir_down_ff && at_floor) begin
          dir_down_ff    <= 1'b0;
          timer_count_ff <= timer_count_ff + 16'h0001;
        end else begin
          timer_count_ff <= dir_down_ff ? timer_count_ff - 16'h0001 : timer_count_ff + 16'h0001;
        end
      end else if (mode != MD_NORMAL && at_top) begin
        timer_count_ff <= CNT_FLOOR;
      end else begin
        timer_count_ff <= timer_count_ff + 16'h0001;
      end
    end
  end

  // Compare buffers; active values load at ceiling in PWM, at once otherwise
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmpa_buf_ff <= 16'h0000;
      cmpb_buf_ff <= 16'h0000;
      compare_value_a_ff <= 16'h0000;
      compare_value_b_ff <= 16'h0000;
    end else begin
      if (wr_low_a) cmpa_buf_ff <= {hold_ff, wb};
      if (wr_low_b) cmpb_buf_ff <= {hold_ff, wb};
      if (!pwm_mode || (tick && (dual_slope ? at_top : at_top))) begin
        compare_value_a_ff <= cmpa_buf_ff;
        compare_value_b_ff <= cmpb_buf_ff;
      end
    end
  end

  assign match_a = timer_count_ff == compare_value_a_ff;
  assign match_b = timer_count_ff == compare_value_b_ff;

  // Noise filter: input must hold steady for NOISE_LEN+1 samples
  assign cap_raw = cap_src_ff ? cmp_sync_ff[1] : cap_sync_ff[1];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap_filt_ff  <= 1'b0;
      noise_cnt_ff <= 2'h0;
    end else if (!timer_control_b_ff[NOISE_EN_BIT] || cap_raw == cap_filt_ff) begin
      noise_cnt_ff <= 2'h0;
      if (!timer_control_b_ff[NOISE_EN_BIT]) cap_filt_ff <= cap_raw;
    end else if (noise_cnt_ff == NOISE_LEN) begin
      cap_filt_ff  <= cap_raw;
      noise_cnt_ff <= 2'h0;
    end else begin
      noise_cnt_ff <= noise_cnt_ff + 2'h1;
    end
  end
  // Event only when the filtered level moves toward the selected edge
  assign cap_event = (timer_control_b_ff[NOISE_EN_BIT] ? (noise_cnt_ff == NOISE_LEN && cap_raw != cap_filt_ff)
                                                       : (cap_raw != cap_filt_ff))
                     && cap_raw == timer_control_b_ff[CAP_EDGE_BIT];

  // Capture register; writable only where it sets the ceiling
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      capture_value_ff <= 16'h0000;
    end else if (top_from_cap && wr_low_cap) begin
      capture_value_ff <= {hold_ff, wb};
    end else if (!top_from_cap && cap_event) begin
      capture_value_ff <= timer_count_ff;
    end
  end

  // Flags: set wins over write-one-to-clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_flag_register_ff <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        logic set_i;
        set_i = (i == FLG_CMPA && tick && match_a) || (i == FLG_CMPB && tick && match_b) ||
                (i == FLG_CAP && !top_from_cap && cap_event) ||
                (i == FLG_OVF && tick && (mode == MD_NORMAL ? at_max : (dual_slope ? at_floor : at_top)));
        if (set_i) timer_flag_register_ff[i] <= 1'b1;
        else if (wr_pend_ff && wr_addr_ff == ADDR_FLAG && wb[i]) timer_flag_register_ff[i] <= 1'b0;
      end
    end
  end

  // Masked requests and wave outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_ff    <= 4'h0;
      wave_a_ff <= 1'b0;
      wave_b_ff <= 1'b0;
    end else begin
      irq_ff <= timer_flag_register_ff & timer_mask_register_ff;
      // Compare A is free for PWM unless it sets the ceiling
      wave_a_ff <= (pwm_mode && top_from_a) ? 1'b0 : match_a;
      wave_b_ff <= match_b;
    end
  end
  assign wave_out_a = wave_a_ff;
  assign wave_out_b = wave_b_ff;
  assign irq_req    = irq_ff;
endmodule

// ### tbc_cpu_model.sv
module tbc_cpu_model
  import tbc_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {hsel, haddr, htrans, hwrite, hsize, hwdata} = {1'b1, 70'h0};

  // One whole-word transfer; several callers, so a byte pair can be split
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    hsize <= 3'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata[7:0];
    hwdata <= ~{24'h0, d}; // Released data no longer shows the value
    // Write lands in the data phase; an idle cycle keeps the next read from seeing stale state
    if (w) @(posedge hclk);
  endtask

  // Wide write, upper byte first
  task automatic w16(input logic [7:0] hi_a, input logic [15:0] v);
    logic [7:0] q;
    xfer(1'b1, hi_a, v[15:8], q);
    xfer(1'b1, hi_a - 8'h04, v[7:0], q);
  endtask

  // Wide read, lower byte first
  task automatic r16(input logic [7:0] lo_a, output logic [15:0] v);
    xfer(1'b0, lo_a, 8'h00, v[7:0]);
    xfer(1'b0, lo_a + 8'h04, 8'h00, v[15:8]);
  endtask
endmodule

// ### tbc_core_monitor.sv
module tbc_core_monitor
  import tbc_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        wave_out_a,
  input wire logic [3:0]  irq_req
);
  logic        ap;
  logic        adp_ff;
  logic        wdp_ff;
  logic        held_ff;
  logic        pwm_a;
  logic [7:0]  adr_ff;
  logic [7:0]  hold_ff;
  logic [7:0]  ctla_ff;
  logic [7:0]  ctlb_ff;
  logic [3:0]  mask_ff;
  logic [15:0] cmpa_ff;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Accepted address phase and compare A as PWM ceiling
  assign ap = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign pwm_a = ({ctlb_ff[4:3], ctla_ff[1:0]} inside {MD_PFC_A, MD_PC_A, MD_FP_A});

  // Remember the pending data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      adp_ff <= 1'b0;
      wdp_ff <= 1'b0;
      adr_ff <= 8'h00;
    end else begin
      adp_ff <= ap;
      wdp_ff <= ap && hwrite;
      adr_ff <= haddr[7:0];
    end
  end

  // Holding byte; only known while no low-byte read has replaced it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hold_ff <= 8'h00;
      held_ff <= 1'b0;
    end else if (wdp_ff && (adr_ff inside {ADDR_CNT_HI, ADDR_CMPA_HI, ADDR_CMPB_HI, ADDR_CAP_HI})) begin
      hold_ff <= hwdata[7:0];
      held_ff <= 1'b1;
    end else if (ap && !hwrite && (haddr[7:0] inside {ADDR_CNT_LO, ADDR_CAP_LO})) begin
      held_ff <= 1'b0;
    end
  end

  // Shadows of plain registers and compare A buffer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctla_ff <= 8'h00;
      ctlb_ff <= 8'h00;
      mask_ff <= 4'h0;
      cmpa_ff <= 16'h0000;
    end else if (wdp_ff) begin
      case (adr_ff)
        ADDR_CTRL_A:  ctla_ff <= hwdata[7:0];
        ADDR_CTRL_B:  ctlb_ff <= hwdata[7:0];
        ADDR_MASK:    mask_ff <= hwdata[3:0];
        ADDR_CMPA_LO: cmpa_ff <= {hold_ff, hwdata[7:0]};
        default:      ;
      endcase
    end
  end

  // Read taken with no write landing at the same edge
  sequence s_read(logic [7:0] a);
    ap && !hwrite && (haddr[7:0] == a) && !wdp_ff;
  endsequence

  property p_back(logic [7:0] a, logic [7:0] v);
    s_read(a) |=> hrdata[7:0] == v;
  endproperty

  chk_ctrl_a_back: assert property (p_back(ADDR_CTRL_A, ctla_ff))
    else $error("control A readback differs");
  chk_ctrl_b_back: assert property (p_back(ADDR_CTRL_B, ctlb_ff))
    else $error("control B readback differs");
  chk_cmp_lo_direct: assert property (p_back(ADDR_CMPA_LO, cmpa_ff[7:0]))
    else $error("compare A low byte differs");
  chk_cmp_hi_direct: assert property (p_back(ADDR_CMPA_HI, cmpa_ff[15:8]))
    else $error("compare A high byte not direct");
  chk_hold_shared: assert property (held_ff ##0 s_read(ADDR_CNT_HI) |=> hrdata[7:0] == hold_ff)
    else $error("high read does not return holding byte");
  chk_upper_zero: assert property (adp_ff && !wdp_ff |-> hrdata[31:8] == 24'h0)
    else $error("read data above the byte not zero");
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus stalled or errored");
  chk_mask_gate: assert property ((irq_req & ~mask_ff & ~$past(mask_ff)) == 4'h0)
    else $error("request raised while masked");
  chk_pwm_a_quiet: assert property (pwm_a [*3] |-> !wave_out_a)
    else $error("channel A output while compare A is ceiling");
endmodule

bind tbc_core tbc_core_monitor mon (.*);

// ### tbc_testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import tbc_pkg::*;

  logic        hclk = 1'b0;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        wave_out_a;
  logic        wave_out_b;
  logic [3:0]  irq_req;
  logic [2:0]  pin_v;
  int          fail_count = 0;
  int          comparisons = 0;
  wire         hready = hreadyout;
  wire         external_count_pin = pin_v[0];
  wire         capture_input_pin = pin_v[1];
  wire         comparator_out = pin_v[2];

`define CHK(n, e, g) begin \
  comparisons++; \
  if ((g) !== (e)) begin \
    fail_count++; \
    $display("unexpected %s expected %h seen %h", n, e, g); \
  end \
end

  // 4 ns clock
  always #2 hclk = ~hclk;

  tbc_core dut (.*);
  tbc_cpu_model cpu (.*);

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    cpu.xfer(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input string n, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    cpu.xfer(1'b0, a, 8'h00, q);
    `CHK(n, e, q)
  endtask

  task automatic r16_chk(input string n, input logic [7:0] a, input logic [15:0] e);
    logic [15:0] v;
    cpu.r16(a, v);
    `CHK(n, e, v)
  endtask

  // Mode bits split over both control registers
  task automatic set_mode(input logic [3:0] m, input logic [2:0] cs, input logic [1:0] cap);
    wr(ADDR_CTRL_A, {6'h00, m[1:0]});
    wr(ADDR_CTRL_B, {cap, 1'b0, m[3:2], cs});
  endtask

  // Levels held 6 cycles so the filter accepts them
  task automatic pulse(input int i, input int n);
    repeat (n) begin
      pin_v[i] <= 1'b1;
      repeat (6) @(posedge hclk);
      pin_v[i] <= 1'b0;
      repeat (6) @(posedge hclk);
    end
  endtask

  task automatic t_access();
    wr(ADDR_CTRL_B, 8'h40);
    wr(ADDR_CTRL_A, 8'h03);
    rd_chk("control b", ADDR_CTRL_B, 8'h40);
    rd_chk("control a", ADDR_CTRL_A, 8'h03);
    set_mode(MD_NORMAL, CS_STOP, 2'h0);
    cpu.w16(ADDR_CNT_HI, 16'h1234);
    r16_chk("count", ADDR_CNT_LO, 16'h1234);
    cpu.w16(ADDR_CMPA_HI, 16'hC3D2);
    wr(ADDR_CMPB_HI, 8'h77);
    rd_chk("hold", ADDR_CNT_HI, 8'h77);
    wr(ADDR_CNT_LO, 8'h11);
    r16_chk("shared hold", ADDR_CNT_LO, 16'h7711);
    rd_chk("compare lo", ADDR_CMPA_LO, 8'hD2);
    rd_chk("compare hi", ADDR_CMPA_HI, 8'hC3);
    rd_chk("hold kept", ADDR_CNT_HI, 8'h77);
    rd_chk("unmapped", 8'h3C, 8'h00);
  endtask

  task automatic t_events();
    cpu.w16(ADDR_CNT_HI, 16'h0100);
    cpu.w16(ADDR_CMPB_HI, 16'h0103);
    wr(ADDR_FLAG, 8'h0F);
    wr(ADDR_MASK, 8'h01 << FLG_CMPB);
    set_mode(MD_NORMAL, CS_EXT_RISE, 2'h0);
    pulse(0, 3);
    r16_chk("rising ticks", ADDR_CNT_LO, 16'h0103);
    `CHK("wave b", 1'b1, wave_out_b)
    // Match flag waits for the next tick while the count sits on the compare value
    `CHK("match before tick", 4'h0, irq_req)
    set_mode(MD_NORMAL, CS_EXT_FALL, 2'h0);
    pulse(0, 2);
    r16_chk("falling ticks", ADDR_CNT_LO, 16'h0105);
    `CHK("match irq", 4'h1 << FLG_CMPB, irq_req)
    wr(ADDR_FLAG, 8'h01 << FLG_CMPB);
    repeat (3) @(posedge hclk);
    `CHK("cleared irq", 4'h0, irq_req)
  endtask

  task automatic t_capture();
    wr(ADDR_FLAG, 8'h0F);
    wr(ADDR_MASK, 8'h01 << FLG_CAP);
    set_mode(MD_NORMAL, CS_STOP, 2'h1);
    pulse(1, 1);
    r16_chk("capture", ADDR_CAP_LO, 16'h0105);
    `CHK("capture irq", 4'h1 << FLG_CAP, irq_req)
    set_mode(MD_NORMAL, CS_STOP, 2'h3);
    cpu.w16(ADDR_CNT_HI, 16'h0200);
    pin_v[1] <= 1'b1;
    repeat (2) @(posedge hclk);
    pin_v[1] <= 1'b0;
    repeat (8) @(posedge hclk);
    r16_chk("spike ignored", ADDR_CAP_LO, 16'h0105);
    pulse(1, 1);
    r16_chk("filtered edge", ADDR_CAP_LO, 16'h0200);
    wr(ADDR_CAPSRC, 8'h01);
    cpu.w16(ADDR_CNT_HI, 16'h0300);
    pulse(2, 1);
    r16_chk("comparator capture", ADDR_CAP_LO, 16'h0300);
  endtask

  // Two ticks from one below each ceiling land on the floor
  task automatic t_ceiling();
    logic [3:0]  md [6] = '{MD_NORMAL, MD_FP8, MD_FP9, MD_FP10, MD_CTC_A, MD_FP_CAP};
    logic [15:0] tp [6] = '{CNT_MAX, TOP_8BIT, TOP_9BIT, TOP_10BIT, 16'hC3D2, 16'h0123};
    wr(ADDR_FLAG, 8'h0F);
    wr(ADDR_MASK, 8'h01 << FLG_OVF);
    for (int i = 0; i < 6; i++) begin
      set_mode(md[i], CS_EXT_RISE, 2'h0);
      cpu.w16(ADDR_CAP_HI, 16'h0123);
      cpu.w16(ADDR_CNT_HI, tp[i] - 16'h0001);
      pulse(0, 2);
      r16_chk("wrap", ADDR_CNT_LO, CNT_FLOOR);
    end
    `CHK("overflow irq", 4'h1 << FLG_OVF, irq_req)
  endtask

  task automatic t_pwm();
    set_mode(MD_FP_A, CS_STOP, 2'h0);
    cpu.w16(ADDR_CNT_HI, 16'hC3D2);
    repeat (4) @(posedge hclk);
    `CHK("wave a ceiling", 1'b0, wave_out_a)
    set_mode(MD_FP_CAP, CS_STOP, 2'h0);
    cpu.w16(ADDR_CAP_HI, 16'hFFFF);
    repeat (4) @(posedge hclk);
    `CHK("wave a free", 1'b1, wave_out_a)
  endtask

  task automatic close_out();
    if (fail_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Main sequence after a 3-cycle reset
  initial begin
    hresetn = 1'b0;
    pin_v = 3'h0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_access();
    t_events();
    t_capture();
    t_ceiling();
    t_pwm();
    close_out();
  end

  // Whole run needs well under a thousand cycles; a hang ends here
  initial begin
    repeat (10000) @(posedge hclk);
    fail_count++;
    close_out();
  end
endmodule
